/* config_crc_error_reporter.v */
// sequencing and reporting of configuration frame crc checks
//
// What this block does
// - checking starts by itself in user mode
// - fault rises after search and message update
// - fault low at least 32 detection ticks
// - later error overwrites message, then raises again
// - checking runs continuously until device reset or until ed_enable_in or user_mode_in drops
// - detection tick is 100 mhz over 2^n
// - one frame checked per detection tick pace
// - fault drives pin only when feature enabled
// - non-zero syndrome drives fault high
// - 46-bit message: type, location, syndrome
`timescale 1ns/10ps
`include "crc_err_regs.vh"
module config_crc_error_reporter #(
    parameter FRAMES    = 16,
    parameter FRAME_W   = 8,
    parameter LOW_TICKS = `FAULT_LOW_MIN_TICKS
) (
    // clock and reset (reset is reconfiguration)
    input  wire                clk_in,
    input  wire                rst_n_in,
    // configuration state
    input  wire                ed_enable_in,
    input  wire                user_mode_in,
    input  wire [3:0]          div_n_in,
    // frame check engine
    input  wire                frame_done_in,
    input  wire [`SYN_W-1:0]   syndrome_in,
    input  wire                search_done_in,
    input  wire [1:0]          err_type_in,
    input  wire [`MSG_LOC_W-1:0] err_loc_in,
    // requests to the frame engine
    output reg                 frame_start_out,
    output reg  [FRAME_W-1:0]  frame_idx_out,
    output reg                 search_start_out,
    // report
    output reg  [`MSG_W-1:0]   err_msg_out,
    output reg                 msg_valid_out,
    output reg                 fault_out,
    output reg                 pin_fault_oe_out,
    output reg                 running_out
);
    ////////////////////////////////////////////////////////////////
    localparam ST_IDLE   = 5'h01;
    localparam ST_CHECK  = 5'h02;
    localparam ST_SEARCH = 5'h04;
    localparam ST_REPORT = 5'h08;
    localparam ST_QUIET  = 5'h10;

    reg  [4:0]         state_r;
    reg  [4:0]         state_nxt;
    reg  [`SYN_W-1:0]  syn_r;
    reg  [6:0]         low_cnt_r;
    reg                wait_frame_r;
    wire               tick;
    wire               go;

    // start needs no external command; any config loss drops straight to idle
    assign go = ed_enable_in & user_mode_in;

    crc_tick_div u_div (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .run_in   (go),
        .div_n_in (div_n_in),
        .tick_out (tick)
    );

    ////////////////////////////////////////////////////////////////
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (go) begin
                    state_nxt = ST_CHECK;
                end
            end
            ST_CHECK: begin
                // only the answer to a frame we asked for counts
                if (frame_done_in && wait_frame_r) begin
                    // hold on the frame result; fault only after the search
                    if (syndrome_in != {`SYN_W{1'b0}}) begin
                        state_nxt = ST_SEARCH;
                    end
                end
            end
            ST_SEARCH: begin
                if (search_done_in) begin
                    state_nxt = ST_REPORT;
                end
            end
            ST_REPORT: begin
                state_nxt = ST_QUIET;
            end
            ST_QUIET: begin
                if (tick && low_cnt_r >= LOW_TICKS[6:0] - 7'h01) begin
                    state_nxt = ST_CHECK;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (!go) begin
            state_nxt = ST_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r          <= ST_IDLE;
            syn_r            <= {`SYN_W{1'b0}};
            low_cnt_r        <= 7'h00;
            wait_frame_r     <= 1'b0;
            frame_start_out  <= 1'b0;
            frame_idx_out    <= {FRAME_W{1'b0}};
            search_start_out <= 1'b0;
            err_msg_out      <= {`MSG_W{1'b0}};
            msg_valid_out    <= 1'b0;
            fault_out        <= 1'b0;
            pin_fault_oe_out <= 1'b0;
            running_out      <= 1'b0;
        end else begin
            state_r          <= state_nxt;
            frame_start_out  <= 1'b0;
            search_start_out <= 1'b0;
            msg_valid_out    <= 1'b0;
            running_out      <= go;
            pin_fault_oe_out <= ed_enable_in;
            // one frame launched per detection tick
            if (state_r == ST_CHECK && state_nxt == ST_CHECK && tick && !wait_frame_r) begin
                frame_start_out <= 1'b1;
                wait_frame_r    <= 1'b1;
            end else if (frame_done_in) begin
                wait_frame_r <= 1'b0;
            end
            if (state_r == ST_CHECK && frame_done_in) begin
                syn_r <= syndrome_in;
                if (frame_idx_out >= FRAMES[FRAME_W-1:0] - {{(FRAME_W-1){1'b0}}, 1'b1}) begin
                    frame_idx_out <= {FRAME_W{1'b0}};
                end else begin
                    frame_idx_out <= frame_idx_out + {{(FRAME_W-1){1'b0}}, 1'b1};
                end
            end
            if (state_r == ST_CHECK && state_nxt == ST_SEARCH) begin
                search_start_out <= 1'b1;
            end
            if (state_r == ST_SEARCH && search_done_in) begin
                // each new report overwrites the last; the monitor must keep up
                err_msg_out   <= {err_type_in, err_loc_in, syn_r};
                msg_valid_out <= 1'b1;
            end
            // fault follows the stored non-zero syndrome, one cycle after the message
            if (go && state_r == ST_REPORT && syn_r != {`SYN_W{1'b0}}) begin
                fault_out <= 1'b1;
            end else begin
                fault_out <= 1'b0;
            end
            if (state_r == ST_QUIET) begin
                if (tick) begin
                    low_cnt_r <= low_cnt_r + 7'h01;
                end
            end else begin
                low_cnt_r <= 7'h00;
            end
            if (!go) begin
                wait_frame_r  <= 1'b0;
                frame_idx_out <= {FRAME_W{1'b0}};
            end
        end
    end
endmodule

/* crc_err_regs.vh */
// constants for the configuration crc error reporter
`ifndef CRC_ERR_REGS_VH
`define CRC_ERR_REGS_VH
`define CFG_OSC_MHZ        100
`define CLK_MHZ            125
`define DIV_N_MIN          4'h1
`define DIV_N_MAX          4'h8
`define DIV_N_RST          4'h1
`define FAULT_LOW_MIN_TICKS 32
`define MSG_W              46
`define SYN_W              16
`define MSG_TYPE_LSB       44
`define MSG_LOC_LSB        16
`define MSG_LOC_W          28
`define MSG_SYN_LSB        0
`endif

/* crc_tick_div.v */
// error detection clock enable: oscillator rate over two to the n
`timescale 1ns/10ps
`include "crc_err_regs.vh"
module crc_tick_div #(
    parameter ACC_W = 16
) (
    // clock and reset
    input  wire       clk_in,
    input  wire       rst_n_in,
    // control
    input  wire       run_in,
    input  wire [3:0] div_n_in,
    // enable pulse
    output reg        tick_out
);
    // phase accumulator models the 100 mhz oscillator from the 125 mhz clock
    reg  [ACC_W-1:0] acc_r;
    reg  [8:0]       pre_r;
    wire [ACC_W:0]   acc_sum;
    wire [3:0]       n_c;
    wire [8:0]       pre_lim;
    // oscillator step per clock, cut to the accumulator width on purpose
    localparam [31:0]      STEP_FULL = (`CFG_OSC_MHZ << ACC_W) / `CLK_MHZ;
    localparam [ACC_W-1:0] STEP      = STEP_FULL[ACC_W-1:0];
    assign acc_sum = {1'b0, acc_r} + {1'b0, STEP};
    // clamp out-of-range divisor settings to the legal 1..8
    assign n_c = (div_n_in < `DIV_N_MIN) ? `DIV_N_MIN : (div_n_in > `DIV_N_MAX) ? `DIV_N_MAX : div_n_in;
    assign pre_lim = (9'h001 << n_c) - 9'h001;
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_r    <= {ACC_W{1'b0}};
            pre_r    <= 9'h000;
            tick_out <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (run_in) begin
                acc_r <= acc_sum[ACC_W-1:0];
                if (acc_sum[ACC_W]) begin
                    if (pre_r >= pre_lim) begin
                        pre_r    <= 9'h000;
                        tick_out <= 1'b1;
                    end else begin
                        pre_r <= pre_r + 9'h001;
                    end
                end
            end else begin
                acc_r <= {ACC_W{1'b0}};
                pre_r <= 9'h000;
            end
        end
    end
endmodule

/* crc_frame_model.sv */
// frame check and location search engine model
`timescale 1ns/10ps
module crc_frame_model (
    // clock and reset
    input  wire        clk_in,
    input  wire        rst_n_in,
    // requests and the answers to give
    input  wire        frame_start_in,
    input  wire        search_start_in,
    input  wire [15:0] syn_in,
    input  wire [1:0]  typ_in,
    input  wire [27:0] loc_in,
    input  wire [3:0]  lat_in,
    // answers
    output reg         frame_done_out = 1'b0,
    output reg         search_done_out = 1'b0,
    output reg  [15:0] syndrome_out = 16'h0000,
    output reg  [1:0]  err_type_out = 2'h0,
    output reg  [27:0] err_loc_out = 28'h0000000
);
    integer fcnt = -1;
    integer scnt = -1;
    // fields toggle between strobes so a stale value is never mistaken for an answer
    always @(posedge clk_in) begin
        frame_done_out <= (fcnt == 0);
        search_done_out <= (scnt == 0);
        syndrome_out <= (fcnt == 0) ? syn_in : ~syndrome_out;
        err_type_out <= (scnt == 0) ? typ_in : ~err_type_out;
        err_loc_out <= (scnt == 0) ? loc_in : ~err_loc_out;
        fcnt <= !rst_n_in ? -1 : frame_start_in ? lat_in - 1 : (fcnt >= 0 ? fcnt - 1 : -1);
        scnt <= !rst_n_in ? -1 : search_start_in ? lat_in - 1 : (scnt >= 0 ? scnt - 1 : -1);
    end
endmodule

/* crc_err_chk.sv */
// assertions on the reporter ports
`timescale 1ns/10ps
`include "crc_err_regs.vh"
module crc_err_chk #(
    parameter LOW_TICKS = 32
) (
    input wire                   clk_in,
    input wire                   rst_n_in,
    input wire                   ed_enable_in,
    input wire                   user_mode_in,
    input wire                   frame_done_in,
    input wire [`SYN_W-1:0]      syndrome_in,
    input wire                   search_done_in,
    input wire [1:0]             err_type_in,
    input wire [`MSG_LOC_W-1:0]  err_loc_in,
    input wire                   frame_start_out,
    input wire                   search_start_out,
    input wire [`MSG_W-1:0]      err_msg_out,
    input wire                   msg_valid_out,
    input wire                   fault_out,
    input wire                   pin_fault_oe_out
);
    // fastest divisor: ticks come 2 or 3 clocks apart, 2.5 on average
    localparam int GAP = LOW_TICKS * 5 / 2 - 1;
    integer quiet;
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            quiet <= GAP;
        else if (fault_out)
            quiet <= 0;
        else if (quiet < GAP)
            quiet <= quiet + 1;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire go = ed_enable_in && user_mode_in;
    sequence s_found; frame_done_in && syndrome_in != 16'h0000 && go; endsequence
    sequence s_report; msg_valid_out ##1 fault_out ##1 !fault_out; endsequence
    a_report_order: assert property (search_done_in && go |=> s_report) else $error("bad report order");
    a_msg_fields: assert property (msg_valid_out |-> err_msg_out[45:16] == $past({err_type_in, err_loc_in})) else $error("bad message");
    a_search_on_err: assert property (s_found |=> search_start_out) else $error("no search");
    a_no_search_zero: assert property (frame_done_in && syndrome_in == 16'h0000 |=> !search_start_out) else $error("search on zero");
    a_fault_cause: assert property (fault_out |-> $past(msg_valid_out)) else $error("fault without message");
    a_fault_spacing: assert property (fault_out |-> quiet >= GAP) else $error("fault too soon");
    a_oe_follow: assert property ($past(rst_n_in) |-> pin_fault_oe_out == $past(ed_enable_in)) else $error("bad pin enable");
    a_idle_low: assert property (!$past(go) |-> !fault_out && !frame_start_out) else $error("active while idle");
endmodule
bind config_crc_error_reporter crc_err_chk #(.LOW_TICKS(LOW_TICKS)) crc_err_chk_i (.*);

/* config_crc_error_reporter_test.sv */
// bench for the configuration crc error reporter
`timescale 1ns/10ps
`define chk(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; $display("mismatch %0t value", $time); end end
module config_crc_error_reporter_test;
    reg         clk_in = 1'b0, rst_n_in = 1'b0, ed_enable_in = 1'b1, user_mode_in = 1'b0;
    reg  [3:0]  div_n_in = 4'h1, lat = 4'h1;
    reg  [1:0]  typ = 2'h0;
    reg  [27:0] loc = 28'h0000000;
    reg  [15:0] syn = 16'h0000;
    wire        frame_done_in, search_done_in, frame_start_out, search_start_out;
    wire        msg_valid_out, fault_out, pin_fault_oe_out, running_out;
    wire [15:0] syndrome_in;
    wire [1:0]  err_type_in;
    wire [27:0] err_loc_in;
    wire [7:0]  frame_idx_out;
    wire [45:0] err_msg_out;
    integer     mismatches = 0, comparisons = 0, cycles = 0, gap, i, seen;
    // rows: latency, type, location, syndrome; message expected is the low 46 bits
    reg  [49:0] rows [0:3] = '{{4'h1, 2'h1, 28'h0000001, 16'h0001}, {4'h4, 2'h2, 28'hfffffff, 16'hffff},
                               {4'h9, 2'h3, 28'h8a5c3e1, 16'h8000}, {4'h2, 2'h0, 28'h0000000, 16'h5a5a}};
    config_crc_error_reporter config_crc_error_reporter_i (.*);
    crc_frame_model crc_frame_model_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .frame_start_in(frame_start_out),
        .search_start_in(search_start_out), .syn_in(syn), .typ_in(typ), .loc_in(loc), .lat_in(lat),
        .frame_done_out(frame_done_in), .search_done_out(search_done_in), .syndrome_out(syndrome_in),
        .err_type_out(err_type_in), .err_loc_out(err_loc_in));
    initial forever #4 clk_in = ~clk_in;
    task finish_test;
        if (mismatches == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // monitor side: the message is unloaded on each rising edge of the fault
    task wait_fault(input integer lim);
        gap = 1;
        @(posedge clk_in) #1;
        while (fault_out !== 1'b1 && gap < lim) begin
            @(posedge clk_in) #1;
            gap = gap + 1;
        end
        `chk(fault_out, 1'b1)
    endtask
    task watch_quiet;
        seen = 0;
        repeat (400) begin
            @(posedge clk_in) #1;
            if (fault_out !== 1'b0) seen = 1;
        end
    endtask
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches++;
            finish_test;
        end
    end
    initial begin
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (i = 0; i < 4; i++) begin
            @(posedge clk_in);
            {lat, typ, loc, syn} <= rows[i];
            user_mode_in <= 1'b1; // no start command: user mode alone starts checking
            wait_fault(1000);
            `chk(err_msg_out, rows[i][45:0])
            if (i > 0) `chk(gap >= 80, 1'b1)
        end
        `chk(running_out, 1'b1)
        @(posedge clk_in);
        syn <= 16'h0000;
        watch_quiet;
        `chk(seen, 0)
        @(posedge clk_in);
        syn <= 16'h0c0c;
        div_n_in <= 4'h8;
        wait_fault(20000);
        wait_fault(20000);
        `chk(gap >= 10240, 1'b1)
        @(posedge clk_in);
        div_n_in <= 4'h1;
        ed_enable_in <= 1'b0;
        watch_quiet;
        `chk({seen, pin_fault_oe_out, running_out}, 3'h0)
        @(posedge clk_in);
        ed_enable_in <= 1'b1;
        rst_n_in <= 1'b0; // reconfiguration request from the monitor
        repeat (2) @(posedge clk_in) #1;
        `chk({fault_out, running_out, frame_idx_out}, 10'h000)
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        wait_fault(1000);
        `chk(err_msg_out[15:0], 16'h0c0c)
        finish_test;
    end
endmodule
